/* File: src/scrd_pkg.sv */
package scrd_pkg;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned SEL_W = 4;

  // Register select codes.
  localparam logic [3:0] SEL_INT = 4'h0;
  localparam logic [3:0] SEL_FRAC = 4'h1;
  localparam logic [3:0] SEL_AUXLOW = 4'h2;
  localparam logic [3:0] SEL_SD = 4'h3;
  localparam logic [3:0] SEL_ADC = 4'hb;
  localparam logic [3:0] SEL_RESYNC = 4'hc;
  localparam logic [3:0] SEL_AUXHIGH = 4'hd;

  // Integer divide word fields.
  localparam int unsigned CAL_BIT = 21;
  localparam int unsigned PRESC_BIT = 20;
  localparam int unsigned INT_LSB = 4;
  localparam int unsigned INT_W = 16;

  // Main fraction word fields.
  localparam int unsigned FRAC_LSB = 4;
  localparam int unsigned FRAC_W = 24;

  // Auxiliary fraction and modulus fields (low and high words share the layout).
  localparam int unsigned AUXF_LSB = 18;
  localparam int unsigned AUXM_LSB = 4;
  localparam int unsigned AUX_W = 14;
  localparam int unsigned AUX_FULL_W = 28;

  // Resync clock value field.
  localparam int unsigned RESYNC_LSB = 12;
  localparam int unsigned RESYNC_W = 20;

  // Modulator load reset disable bit in the control word with select code 3.
  localparam int unsigned SDRST_DIS_BIT = 30;

  // Reset values.
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WORD_RESET = 32'h0020_0000;

  // Frame capture states.
  typedef enum logic [1:0] {
    SCRD_IDLE = 2'b00,
    SCRD_SHIFT = 2'b01,
    SCRD_DONE = 2'b10
  } scrd_state_t;

endpackage

/* File: src/scrd_shift_in.sv */
`timescale 1ns/1ps
module scrd_shift_in (
  // System.
  input wire logic clk_sys,
  input wire logic reset,
  // Serial pins.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Captured word.
  output logic [scrd_pkg::WORD_W-1:0] word,
  output logic word_valid
);
  import scrd_pkg::*;

  typedef struct packed {
    logic [2:0] clk_s;
    logic [1:0] dat_s;
    logic [2:0] le_s;
    logic [WORD_W-1:0] shreg;
    logic [5:0] count;
    scrd_state_t state;
    logic [WORD_W-1:0] word;
    logic word_valid;
  } scrd_shift_t;

  scrd_shift_t st;
  scrd_shift_t next_st;

  always_comb begin
    next_st = st;
    next_st.clk_s = {st.clk_s[1:0], ser_clk};
    next_st.dat_s = {st.dat_s[0], ser_data};
    next_st.le_s = {st.le_s[1:0], ser_le};
    next_st.word_valid = 1'b0;
    case (st.state)
      SCRD_IDLE: begin
        next_st.count = 6'h00;
        if (!st.le_s[1]) begin
          next_st.state = SCRD_SHIFT;
        end
      end
      SCRD_SHIFT: begin
        if (st.clk_s[1] && !st.clk_s[2]) begin
          next_st.shreg = {st.shreg[WORD_W-2:0], st.dat_s[1]};
          if (st.count != 6'h20) begin
            next_st.count = st.count + 6'h01;
          end
        end
        if (st.le_s[1] && !st.le_s[2]) begin
          next_st.state = SCRD_DONE;
        end
      end
      SCRD_DONE: begin
        // A short frame is dropped; a frame of 32 or more bits latches its last 32 bits.
        if (st.count == 6'h20) begin
          next_st.word = st.shreg;
          next_st.word_valid = 1'b1;
        end
        next_st.state = SCRD_IDLE;
      end
      default: begin
        next_st.state = SCRD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.clk_s <= 3'b000;
      st.le_s <= 3'b111;
      st.state <= SCRD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.word;
  assign word_valid = st.word_valid;

endmodule

/* File: src/scrd_cal_seq.sv */
`timescale 1ns/1ps
module scrd_cal_seq #(
  parameter int unsigned CAL_CYCLES = 64
) (
  // System.
  input wire logic clk_sys,
  input wire logic reset,
  // Control.
  input wire logic start,
  // Status.
  output logic busy,
  output logic band_load
);
  import scrd_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic busy;
    logic band_load;
  } scrd_cal_t;

  scrd_cal_t st;
  scrd_cal_t next_st;

  always_comb begin
    next_st = st;
    next_st.band_load = 1'b0;
    if (start) begin
      next_st.busy = 1'b1;
      next_st.count = 16'(CAL_CYCLES - 1);
    end else if (st.busy) begin
      if (st.count == 16'h0000) begin
        next_st.busy = 1'b0;
        next_st.band_load = 1'b1;
      end else begin
        next_st.count = st.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign band_load = st.band_load;

endmodule

/* File: src/scrd_top.sv */
`timescale 1ns/1ps
module scrd_top #(
  parameter int unsigned CAL_CYCLES = 64
) (
  // System.
  input wire logic clk_sys,
  input wire logic reset,
  // Serial load pins.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Active integer and prescaler settings.
  output logic [scrd_pkg::INT_W-1:0] int_value,
  output logic prescaler_select_bit,
  output logic cal_enable_bit,
  // Active fractional, resync and ADC and band control settings.
  output logic [scrd_pkg::FRAC_W-1:0] main_fraction_numerator,
  output logic [scrd_pkg::AUX_FULL_W-1:0] aux_fraction_numerator,
  output logic [scrd_pkg::AUX_W-1:0] aux_modulus_high,
  output logic [scrd_pkg::RESYNC_W-1:0] resync_value,
  output logic [scrd_pkg::WORD_W-1:0] adc_and_band_control_word,
  // Events and status.
  output logic modulator_reset,
  output logic vco_auto_calibration,
  output logic cal_busy,
  output logic band_load
);
  import scrd_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] integer_divide_word;
    logic [WORD_W-1:0] main_fraction_shadow;
    logic [WORD_W-1:0] main_fraction_word;
    logic [WORD_W-1:0] aux_low_shadow;
    logic [WORD_W-1:0] aux_low_word;
    logic [WORD_W-1:0] aux_fraction_high_shadow;
    logic [WORD_W-1:0] aux_fraction_high_word;
    logic [WORD_W-1:0] sd_control_word;
    logic [WORD_W-1:0] phase_resync_clock_word;
    logic [WORD_W-1:0] adc_and_band_control_word;
    logic modulator_reset;
    logic cal_start;
  } scrd_top_t;

  scrd_top_t st;
  scrd_top_t next_st;
  logic [WORD_W-1:0] word;
  logic word_valid;

  function automatic logic [AUX_W-1:0] aux_frac_of(input logic [WORD_W-1:0] w);
    aux_frac_of = w[AUXF_LSB +: AUX_W];
  endfunction

  scrd_shift_in u_shift (
    .clk_sys(clk_sys),
    .reset(reset),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le),
    .word(word),
    .word_valid(word_valid)
  );

  scrd_cal_seq #(
    .CAL_CYCLES(CAL_CYCLES)
  ) u_cal (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(st.cal_start),
    .busy(cal_busy),
    .band_load(band_load)
  );

  always_comb begin
    next_st = st;
    next_st.modulator_reset = 1'b0;
    next_st.cal_start = 1'b0;
    if (word_valid) begin
      case (word[SEL_W-1:0])
        SEL_INT: begin
          next_st.integer_divide_word = word;
          // Shadowed words are promoted by this write.
          next_st.main_fraction_word = st.main_fraction_shadow;
          next_st.aux_low_word = st.aux_low_shadow;
          next_st.aux_fraction_high_word = st.aux_fraction_high_shadow;
          next_st.cal_start = word[CAL_BIT];
          next_st.modulator_reset = !st.sd_control_word[SDRST_DIS_BIT];
        end
        SEL_FRAC: begin
          next_st.main_fraction_shadow = word;
        end
        SEL_AUXLOW: begin
          next_st.aux_low_shadow = word;
        end
        SEL_SD: begin
          next_st.sd_control_word = word;
        end
        SEL_ADC: begin
          next_st.adc_and_band_control_word = word;
        end
        SEL_RESYNC: begin
          next_st.phase_resync_clock_word = word;
        end
        SEL_AUXHIGH: begin
          next_st.aux_fraction_high_shadow = word;
        end
        default: begin
          next_st = st;
          next_st.modulator_reset = 1'b0;
          next_st.cal_start = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.integer_divide_word <= CTRL_WORD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign int_value = st.integer_divide_word[INT_LSB +: INT_W];
  assign prescaler_select_bit = st.integer_divide_word[PRESC_BIT];
  assign cal_enable_bit = st.integer_divide_word[CAL_BIT];
  assign main_fraction_numerator = st.main_fraction_word[FRAC_LSB +: FRAC_W];
  // Full auxiliary fraction is high part shifted by 14 plus the low part.
  assign aux_fraction_numerator = {aux_frac_of(st.aux_fraction_high_word),
                                   aux_frac_of(st.aux_low_word)};
  assign aux_modulus_high = st.aux_fraction_high_word[AUXM_LSB +: AUX_W];
  assign resync_value = st.phase_resync_clock_word[RESYNC_LSB +: RESYNC_W];
  assign adc_and_band_control_word = st.adc_and_band_control_word;
  assign modulator_reset = st.modulator_reset;
  assign vco_auto_calibration = st.cal_start;

endmodule

/* File: sim/scrd_top_checker.sv */
`timescale 1ns/1ps
module scrd_top_checker #(
  parameter int unsigned CAL_CYCLES = 64
) (
  // System.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ser_le,
  // Watched outputs.
  input wire logic [scrd_pkg::INT_W-1:0] int_value,
  input wire logic [scrd_pkg::FRAC_W-1:0] main_fraction_numerator,
  input wire logic [scrd_pkg::WORD_W-1:0] adc_and_band_control_word,
  input wire logic cal_enable_bit,
  input wire logic modulator_reset,
  input wire logic vco_auto_calibration,
  input wire logic cal_busy,
  input wire logic band_load
);
  import scrd_pkg::*;
  localparam int BL = CAL_CYCLES + 3;
  logic [3:0] since_le;
  logic le_q;
  // Counts cycles since the load pin last rose, saturating.
  always_ff @(posedge clk_sys) begin
    le_q <= ser_le;
    if (reset || (ser_le && !le_q)) begin
      since_le <= 4'h0;
    end else if (since_le != 4'hf) begin
      since_le <= since_le + 4'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_cal_starts_busy: assert property (vco_auto_calibration |=> cal_busy)
    else $error("busy missing");
  a_cal_one_cycle: assert property (vco_auto_calibration |=> !vco_auto_calibration)
    else $error("long cal pulse");
  a_mrst_one_cycle: assert property (modulator_reset |=> !modulator_reset)
    else $error("long reset pulse");
  a_band_one_cycle: assert property (band_load |=> !band_load)
    else $error("long band pulse");
  a_busy_to_band: assert property ($rose(cal_busy) |-> ##[1:BL] band_load)
    else $error("band load late");
  a_int_after_load: assert property (!$stable(int_value) |-> since_le < 4'hc)
    else $error("int changed off frame");
  a_frac_after_load: assert property (!$stable(main_fraction_numerator) |-> since_le < 4'hc)
    else $error("frac changed off frame");
  a_adc_after_load: assert property (!$stable(adc_and_band_control_word) |-> since_le < 4'hc)
    else $error("adc changed off frame");
  a_cal_after_load: assert property (vco_auto_calibration |-> since_le < 4'hc)
    else $error("cal off frame");
  a_reset_cal_on: assert property ($fell(reset) |-> cal_enable_bit)
    else $error("cal enable reset value");
  cover property (vco_auto_calibration);
  cover property (modulator_reset);
  cover property (band_load);
endmodule
bind scrd_top scrd_top_checker #(.CAL_CYCLES(CAL_CYCLES)) chk_u (
  .clk_sys(clk_sys), .reset(reset), .ser_le(ser_le), .int_value(int_value),
  .main_fraction_numerator(main_fraction_numerator),
  .adc_and_band_control_word(adc_and_band_control_word), .cal_enable_bit(cal_enable_bit),
  .modulator_reset(modulator_reset), .vco_auto_calibration(vco_auto_calibration),
  .cal_busy(cal_busy), .band_load(band_load)
);

/* File: sim/scrd_host_model.sv */
`timescale 1ns/1ps
module scrd_host_model (
  // Clock.
  input wire logic clk_sys,
  // Serial pins.
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b1;
  end
  // Holds each pin level 4 cycles, longer than the pin synchronizer needs.
  task automatic hold();
    repeat (4) @(posedge clk_sys);
  endtask
  // Sends the top n bits MSB first; a short n makes a broken frame.
  task automatic send(input logic [31:0] w, input int n);
    ser_le <= 1'b0;
    hold();
    for (int i = 31; i > 31 - n; i--) begin
      ser_data <= w[i];
      hold();
      ser_clk <= 1'b1;
      hold();
      ser_clk <= 1'b0;
    end
    hold();
    ser_le <= 1'b1;
    ser_data <= ~ser_data;
    hold();
  endtask
endmodule

/* File: sim/scrd_top_test.sv */
`timescale 1ns/1ps
module scrd_top_test;
  import scrd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sc, sd, le, pr, ce, mr, vc, cb, bl;
  logic [INT_W-1:0] iv;
  logic [FRAC_W-1:0] fr;
  logic [AUX_FULL_W-1:0] ax;
  logic [AUX_W-1:0] am;
  logic [RESYNC_W-1:0] rs;
  logic [WORD_W-1:0] ad;
  logic [3:0] bad [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'he, 4'hf};
  int n_errors = 0, tests_run = 0, n_cal = 0, n_mr = 0, n_bl = 0;
  scrd_host_model host_u (.clk_sys(clk_sys), .ser_clk(sc), .ser_data(sd), .ser_le(le));
  scrd_top #(.CAL_CYCLES(4)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .ser_clk(sc), .ser_data(sd), .ser_le(le),
    .int_value(iv), .prescaler_select_bit(pr), .cal_enable_bit(ce),
    .main_fraction_numerator(fr), .aux_fraction_numerator(ax), .aux_modulus_high(am),
    .resync_value(rs), .adc_and_band_control_word(ad), .modulator_reset(mr),
    .vco_auto_calibration(vc), .cal_busy(cb), .band_load(bl)
  );
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_cal <= n_cal + (vc === 1'b1);
    n_mr <= n_mr + (mr === 1'b1);
    n_bl <= n_bl + (bl === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] w, input int n = 32);
    host_u.send(w, n);
    repeat (16) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] w0(input logic c, input logic p, input logic [15:0] v);
    return {10'h000, c, p, v, SEL_INT};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("cal_en", ce, 1);
    wr({4'h0, 24'hab_cdef, SEL_FRAC});
    wr({14'h2aaa, 14'h0155, SEL_AUXLOW});
    wr({14'h0777, 14'h1234, SEL_AUXHIGH});
    chk("frac", fr, 0);
    chk("aux", ax, 0);
    chk("int", iv, 0);
    wr(w0(1'b1, 1'b1, 16'hbeef));
    chk("int", iv, 16'hbeef);
    chk("presc", pr, 1);
    chk("frac", fr, 24'hab_cdef);
    chk("aux", ax, {14'h0777, 14'h2aaa});
    chk("auxm", am, 14'h1234);
    chk("cal", n_cal, 1);
    chk("mrst", n_mr, 1);
    chk("band", n_bl, 1);
    wr(w0(1'b0, 1'b0, 16'h0017));
    chk("int", iv, 16'h0017);
    chk("presc", pr, 0);
    chk("cal_en", ce, 0);
    chk("cal", n_cal, 1);
    chk("band", n_bl, 1);
    chk("mrst", n_mr, 2);
    wr(32'h4000_0003);
    wr(w0(1'b1, 1'b0, 16'h7fff));
    chk("mrst", n_mr, 2);
    chk("cal", n_cal, 2);
    wr({20'habcde, 8'h00, SEL_RESYNC});
    chk("resync", rs, 20'habcde);
    wr(32'h1234_567b);
    chk("adc", ad, 32'h1234_567b);
    foreach (bad[k]) begin
      wr({28'hfff_fff0, bad[k]});
      chk("int", iv, 16'h7fff);
      chk("adc", ad, 32'h1234_567b);
      chk("resync", rs, 20'habcde);
    end
    wr(w0(1'b1, 1'b1, 16'h0055), 31);
    chk("int", iv, 16'h7fff);
    chk("cal", n_cal, 2);
    conclude();
  end
endmodule
